//--- ssr_defines.svh
`ifndef SSR_DEFINES_SVH
`define SSR_DEFINES_SVH
// Register offsets (register index, byte address is four times)
`define SSR_IDX_IRQ_FLAGS 8'h0C
`define SSR_IDX_RX_STATUS 8'h18
`define SSR_IDX_TX_BUFFER 8'h19
`define SSR_IDX_RX_BUFFER 8'h1A
`define SSR_IDX_IRQ_ENABLES 8'h8C
`define SSR_IDX_TX_STATUS 8'h98
`define SSR_IDX_BAUD_DIV 8'h99
`define SSR_IDX_CONTROL 8'hA0
// receive_status_control fields
`define SSR_RS_PORT_EN 7
`define SSR_RS_NINE_EN 6
`define SSR_RS_SINGLE_EN 5
`define SSR_RS_CONT_EN 4
`define SSR_RS_ADDR_DET 3
`define SSR_RS_FRAME_ERR 2
`define SSR_RS_OVERRUN 1
`define SSR_RS_NINTH 0
// transmit_status_control fields
`define SSR_TS_CLK_SRC 7
`define SSR_TS_SYNC 4
// irq flag / enable field
`define SSR_IRQ_RX 5
// control register fields
`define SSR_CTL_SLEEP 0
`define SSR_CTL_GIE 1
// Reset value and interrupt vector
`define SSR_RST_TX_STATUS 8'h02
`define SSR_IRQ_VECTOR 16'h0004
`endif

//--- ssr_pkg.sv
package ssr_pkg;
  typedef enum logic [3:0] {
    SSR_M_IDLE = 4'h1,
    SSR_M_BIT_LOW = 4'h2,
    SSR_M_BIT_HIGH = 4'h4,
    SSR_M_GAP = 4'h8
  } ssr_mstate_type;
endpackage

//--- ssr_link_if.sv
`timescale 1ns/1ps
interface ssr_link_if;
  logic serial_clock_pin;
  logic serial_data_pin;
  modport device (input serial_clock_pin, input serial_data_pin);
  modport master (output serial_clock_pin, output serial_data_pin);
endinterface

//--- ssr_master.sv
`timescale 1ns/1ps
`include "ssr_defines.svh"
module ssr_master (
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  ssr_link_if.master LINK,
  input wire logic [8:0] WORD,
  input wire logic NINE,
  input wire logic START,
  input wire logic [7:0] HALF_PERIOD,
  output logic BUSY
);
  typedef struct packed {
    ssr_pkg::ssr_mstate_type st;
    logic [8:0] sh;
    logic [3:0] left;
    logic [7:0] cnt;
    logic clk;
    logic dat;
    logic busy;
  } ssr_mst_type;
  ssr_mst_type r, next_r;
  assign LINK.serial_clock_pin = r.clk;
  assign LINK.serial_data_pin = r.dat;
  assign BUSY = r.busy;
  // Shift clock divider; data changes while clock high, device samples on fall
  always_comb begin
    next_r = r;
    case (r.st)
      ssr_pkg::SSR_M_IDLE: begin
        next_r.clk = 1'b0;
        next_r.busy = 1'b0;
        if (START) begin
          next_r.sh = WORD;
          next_r.left = NINE ? 4'h9 : 4'h8;
          next_r.busy = 1'b1;
          next_r.cnt = 8'h00;
          next_r.st = ssr_pkg::SSR_M_BIT_HIGH;
        end
      end
      ssr_pkg::SSR_M_BIT_HIGH: begin
        next_r.clk = 1'b1;
        if (r.cnt == 8'h00) begin
          next_r.dat = r.sh[0];
        end
        if (r.cnt == HALF_PERIOD) begin
          next_r.cnt = 8'h00;
          next_r.clk = 1'b0;
          next_r.sh = {1'b0, r.sh[8:1]};
          next_r.left = r.left - 4'h1;
          next_r.st = ssr_pkg::SSR_M_BIT_LOW;
        end else begin
          next_r.cnt = r.cnt + 8'h01;
        end
      end
      ssr_pkg::SSR_M_BIT_LOW: begin
        if (r.cnt == HALF_PERIOD) begin
          next_r.cnt = 8'h00;
          next_r.st = (r.left == 4'h0) ? ssr_pkg::SSR_M_GAP : ssr_pkg::SSR_M_BIT_HIGH;
        end else begin
          next_r.cnt = r.cnt + 8'h01;
        end
      end
      ssr_pkg::SSR_M_GAP: begin
        next_r.st = ssr_pkg::SSR_M_IDLE;
      end
      default: begin
        next_r.st = ssr_pkg::SSR_M_IDLE;
      end
    endcase
  end
  // State register
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      r <= '{st: ssr_pkg::SSR_M_IDLE, sh: 9'h000, left: 4'h0, cnt: 8'h00,
             clk: 1'b0, dat: 1'b0, busy: 1'b0};
    end else begin
      r <= next_r;
    end
  end
endmodule

//--- ssr_device.sv
`timescale 1ns/1ps
`include "ssr_defines.svh"
// How it works
// - Slave reception matches master reception except sleep
// - Single receive enable ignored in slave mode
// - Continuous enable keeps receiving while asleep
// - Last bit moves shift register into buffer
// - Word in sleep with enable wakes device
// - Wake with global enable vectors to 0004h
// - Software selects sync, enable, external clock
// - Flag on completion, request only when enabled
// - Nine bit mode stores extra ninth bit
// - Software sets continuous enable after configuration
// - Software reads status before reading buffer
// - Buffer read returns oldest word low byte
// - Clearing continuous enable clears the error
// - Data sampled on falling shift clock edge
// - Shift clock comes from external pin
// - Full two-entry buffer: overrun, drop, block
// - Flag clears only when buffer read empty
module ssr_device (
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  ssr_link_if.device LINK,
  input wire logic [31:0] WB_ADR_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic WB_WE_I,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  output logic IRQ,
  output logic WAKE,
  output logic VECTOR_VALID,
  output logic [15:0] VECTOR
);
  typedef struct packed {
    logic [2:0] clk_s;
    logic [1:0] dat_s;
    logic [7:0] rx_status;
    logic [7:0] tx_status;
    logic [7:0] irq_en;
    logic [7:0] baud;
    logic [7:0] tx_buf;
    logic [7:0] ctl;
    logic [8:0] shreg;
    logic [3:0] nbits;
    logic [8:0] fifo0;
    logic [8:0] fifo1;
    logic [1:0] count;
    logic rx_flag;
    logic overrun;
    logic [31:0] rdata;
    logic ack;
    logic irq;
    logic wake;
    logic vec_valid;
    logic [15:0] vector;
  } ssr_dev_type;
  ssr_dev_type r, next_r;
  logic [7:0] idx;
  logic bus_req;
  logic wr_byte;
  logic fall;
  logic slave_on;
  logic nine;
  logic [8:0] word;
  logic [7:0] status_rd;
  // Bus decode, link edge and buffer events
  logic last_bit;
  logic pop;
  logic store;
  // Register index and one bus request per classic cycle
  assign idx = WB_ADR_I[9:2];
  assign bus_req = WB_CYC_I && WB_STB_I && !r.ack;
  assign wr_byte = bus_req && WB_WE_I && WB_SEL_I[0];
  assign fall = r.clk_s[2] && !r.clk_s[1];
  // Reception needs port, sync mode, external clock, continuous enable
  assign slave_on = r.rx_status[`SSR_RS_PORT_EN] && r.tx_status[`SSR_TS_SYNC]
                    && !r.tx_status[`SSR_TS_CLK_SRC] && r.rx_status[`SSR_RS_CONT_EN];
  // Word width select
  assign nine = r.rx_status[`SSR_RS_NINE_EN];
  // Word presently assembled, nine-bit aligned to bit 0
  assign word = nine ? {r.dat_s[1], r.shreg[8:1]} :
                {1'b0, r.dat_s[1], r.shreg[8:2]};
  assign status_rd = {r.rx_status[7:3], 1'b0, r.overrun, r.fifo0[8]};
  // Last falling edge of a word, and buffer read that takes the oldest word
  assign last_bit = slave_on && fall && (r.nbits == (nine ? 4'h8 : 4'h7));
  assign pop = bus_req && !WB_WE_I && (idx == `SSR_IDX_RX_BUFFER) && (r.count != 2'h0);
  // A full buffer accepts the word only when the same cycle reads one out
  assign store = last_bit && !r.overrun && ((r.count != 2'h2) || pop);
  // Outputs straight from the state register
  assign WB_DAT_O = r.rdata;
  assign WB_ACK_O = r.ack;
  assign IRQ = r.irq;
  assign WAKE = r.wake;
  assign VECTOR_VALID = r.vec_valid;
  assign VECTOR = r.vector;
  always_comb begin
    next_r = r;
    // Two-flop synchronisers, third clock stage for edge detection
    next_r.clk_s = {r.clk_s[1:0], LINK.serial_clock_pin};
    next_r.dat_s = {r.dat_s[0], LINK.serial_data_pin};
    next_r.ack = bus_req;
    next_r.rdata = 32'h0000_0000;
    next_r.wake = 1'b0;
    // Shift on falling edge of external clock only, divisor unused
    if (!slave_on) begin
      next_r.nbits = 4'h0;
    end else if (fall) begin
      next_r.shreg = {r.dat_s[1], r.shreg[8:1]};
      next_r.nbits = last_bit ? 4'h0 : r.nbits + 4'h1;
    end
    // Full buffer with no read this cycle: word lost, further words blocked
    if (last_bit && !r.overrun && !store) begin
      next_r.overrun = 1'b1;
    end
    // Buffer update; a read and a store in one cycle both take effect
    case ({store, pop})
      2'b10: begin
        if (r.count == 2'h0) begin
          next_r.fifo0 = word;
        end else begin
          next_r.fifo1 = word;
        end
        next_r.count = r.count + 2'h1;
      end
      2'b01: begin
        next_r.fifo0 = r.fifo1;
        next_r.count = r.count - 2'h1;
      end
      2'b11: begin
        if (r.count == 2'h1) begin
          next_r.fifo0 = word;
        end else begin
          next_r.fifo0 = r.fifo1;
          next_r.fifo1 = word;
        end
      end
      default: begin
        next_r.count = r.count;
      end
    endcase
    // Flag set by a store wins over the read that empties the buffer
    if (store) begin
      next_r.rx_flag = 1'b1;
    end else if (pop && r.count == 2'h1) begin
      next_r.rx_flag = 1'b0;
    end
    // Word stored while asleep with enable wakes the device
    if (store && r.ctl[`SSR_CTL_SLEEP] && r.irq_en[`SSR_IRQ_RX]) begin
      next_r.wake = 1'b1;
      next_r.ctl[`SSR_CTL_SLEEP] = 1'b0;
      if (r.ctl[`SSR_CTL_GIE]) begin
        next_r.vec_valid = 1'b1;
        next_r.vector = `SSR_IRQ_VECTOR;
      end
    end
    // Register reads
    if (bus_req && !WB_WE_I) begin
      case (idx)
        `SSR_IDX_IRQ_FLAGS: next_r.rdata = {24'h000000, 2'h0, r.rx_flag, 5'h00};
        `SSR_IDX_RX_STATUS: next_r.rdata = {24'h000000, status_rd};
        `SSR_IDX_RX_BUFFER: next_r.rdata = {24'h000000, r.fifo0[7:0]};
        `SSR_IDX_IRQ_ENABLES: next_r.rdata = {24'h000000, r.irq_en};
        `SSR_IDX_TX_STATUS: next_r.rdata = {24'h000000, r.tx_status};
        `SSR_IDX_BAUD_DIV: next_r.rdata = {24'h000000, r.baud};
        `SSR_IDX_CONTROL: next_r.rdata = {24'h000000, r.ctl};
        default: next_r.rdata = 32'h0000_0000;
      endcase
    end
    // Register writes; flag and status bits are read only
    if (wr_byte) begin
      case (idx)
        `SSR_IDX_RX_STATUS: begin
          next_r.rx_status = {WB_DAT_I[7:3], 3'h0};
          if (!WB_DAT_I[`SSR_RS_CONT_EN] && r.overrun) begin
            next_r.overrun = 1'b0;
          end
        end
        `SSR_IDX_TX_BUFFER: next_r.tx_buf = WB_DAT_I[7:0];
        `SSR_IDX_IRQ_ENABLES: next_r.irq_en = WB_DAT_I[7:0];
        `SSR_IDX_TX_STATUS: next_r.tx_status = {WB_DAT_I[7:2], 1'b1, WB_DAT_I[0]};
        `SSR_IDX_BAUD_DIV: next_r.baud = WB_DAT_I[7:0];
        `SSR_IDX_CONTROL: next_r.ctl = {6'h00, WB_DAT_I[1:0]};
        default: next_r.baud = r.baud;
      endcase
    end
    // Control write releases the vector unless a wake sets it this cycle
    if (r.vec_valid && wr_byte && idx == `SSR_IDX_CONTROL && !next_r.wake) begin
      next_r.vec_valid = 1'b0;
    end
    // Level request from flag and enable as they will stand
    next_r.irq = next_r.rx_flag && next_r.irq_en[`SSR_IRQ_RX];
  end
  // State register
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      r <= '{clk_s: 3'h0, dat_s: 2'h0, rx_status: 8'h00, tx_status: `SSR_RST_TX_STATUS,
             irq_en: 8'h00, baud: 8'h00, tx_buf: 8'h00, ctl: 8'h00, shreg: 9'h000,
             nbits: 4'h0, fifo0: 9'h000, fifo1: 9'h000, count: 2'h0, rx_flag: 1'b0,
             overrun: 1'b0, rdata: 32'h0000_0000, ack: 1'b0, irq: 1'b0, wake: 1'b0,
             vec_valid: 1'b0, vector: 16'h0000};
    end else begin
      r <= next_r;
    end
  end
endmodule

//--- ssr_link_assertions.sv
`timescale 1ns/1ps
module ssr_link_assertions (
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  input wire logic sclk,
  input wire logic sdata,
  input wire logic BUSY,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_ACK_O,
  input wire logic WAKE,
  input wire logic VECTOR_VALID,
  input wire logic [15:0] VECTOR
);
  default clocking dc @(posedge CLK_SYS); endclocking
  default disable iff (!RESET_N);
  // Bus answer timing
  ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack held");
  ack_take_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("no ack");
  ack_cause_a: assert property (WB_ACK_O |-> $past(WB_STB_I)) else $error("stray ack");
  // Shift clock and data on the link
  high_hold_a: assert property ($rose(sclk) |=> sclk [*8]) else $error("short high");
  low_hold_a: assert property ($fell(sclk) |=> !sclk [*8]) else $error("short low");
  fall_data_a: assert property ($fell(sclk) |-> $stable(sdata)) else $error("data moved");
  clk_busy_a: assert property ($rose(sclk) |-> BUSY || $past(BUSY)) else $error("idle clk");
  // Wake and vector
  wake_pulse_a: assert property (WAKE |=> !WAKE) else $error("wake held");
  vector_wake_a: assert property ($rose(VECTOR_VALID) |-> WAKE || $past(WAKE))
    else $error("vector without wake");
  vector_addr_a: assert property (VECTOR_VALID |-> VECTOR == 16'h0004)
    else $error("bad vector");
endmodule

//--- sync_serial_slave_receiver_test.sv
`timescale 1ns/1ps
module sync_serial_slave_receiver_test;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [31:0] adr = 32'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] rv;
  logic ack, irq, wake, vvalid, busy;
  logic [15:0] vec;
  logic [8:0] word = 9'h000;
  logic nine = 1'b0;
  logic start = 1'b0;
  logic woke = 1'b0;
  int err_count = 0;
  int n_compared = 0;
  int cycles = 0;
  ssr_link_if link ();
  always #2 clk_sys = ~clk_sys;
  ssr_master u_ssr_master (.CLK_SYS(clk_sys), .RESET_N(reset_n), .LINK(link), .WORD(word),
    .NINE(nine), .START(start), .HALF_PERIOD(8'h13), .BUSY(busy));
  ssr_device u_ssr_device (.CLK_SYS(clk_sys), .RESET_N(reset_n), .LINK(link), .WB_ADR_I(adr),
    .WB_DAT_I(wdat), .WB_SEL_I(4'hF), .WB_WE_I(we), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_DAT_O(rdat), .WB_ACK_O(ack), .IRQ(irq), .WAKE(wake), .VECTOR_VALID(vvalid),
    .VECTOR(vec));
  ssr_link_assertions u_ssr_link_assertions (.CLK_SYS(clk_sys), .RESET_N(reset_n),
    .sclk(link.serial_clock_pin), .sdata(link.serial_data_pin), .BUSY(busy),
    .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_ACK_O(ack), .WAKE(wake), .VECTOR_VALID(vvalid), .VECTOR(vec));
  // Wake catcher and hang guard
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (wake === 1'b1) woke <= 1'b1;
    if (cycles == 20000) begin
      err_count++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("compared %0d mismatched %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Classic single bus cycle
  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {22'h0, idx, 2'h0};
    wdat <= {24'h0, d};
    do @(posedge clk_sys); while (ack !== 1'b1);
    rv = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
    wb(1'b0, idx, 8'h00);
    chk(rv, exp);
  endtask
  // One word from the link master
  task automatic send(input logic [8:0] w, input logic n9);
    @(posedge clk_sys);
    word <= w;
    nine <= n9;
    start <= 1'b1;
    @(posedge clk_sys);
    start <= 1'b0;
    do @(posedge clk_sys); while (busy === 1'b1);
    repeat (8) @(posedge clk_sys);
  endtask
  // Main sequence
  initial begin
    repeat (6) @(posedge clk_sys);
    reset_n <= 1'b1;
    rd(8'h98, 32'h02);
    rd(8'h18, 32'h00);
    rd(8'h0C, 32'h00);
    rd(8'hA0, 32'h00);
    rd(8'h77, 32'h00);
    $display("reset test done");
    wb(1'b1, 8'h99, 8'hFF);
    wb(1'b1, 8'h98, 8'h10);
    rd(8'h99, 32'hFF);
    rd(8'h98, 32'h12);
    wb(1'b1, 8'h8C, 8'h20);
    wb(1'b1, 8'h18, 8'hA0);
    send(9'h0A5, 1'b0);
    rd(8'h0C, 32'h00);
    wb(1'b1, 8'h18, 8'hB0);
    send(9'h0A5, 1'b0);
    chk(32'(irq), 32'h1);
    rd(8'h0C, 32'h20);
    rd(8'h18, 32'hB0);
    rd(8'h1A, 32'hA5);
    rd(8'h0C, 32'h00);
    $display("eight bit test done");
    wb(1'b1, 8'h18, 8'hF0);
    send(9'h1C3, 1'b1);
    send(9'h05A, 1'b1);
    rd(8'h18, 32'hF1);
    rd(8'h1A, 32'hC3);
    rd(8'h0C, 32'h20);
    rd(8'h18, 32'hF0);
    rd(8'h1A, 32'h5A);
    $display("nine bit test done");
    send(9'h111, 1'b1);
    send(9'h022, 1'b1);
    send(9'h033, 1'b1);
    rd(8'h18, 32'hF3);
    rd(8'h1A, 32'h11);
    send(9'h044, 1'b1);
    rd(8'h1A, 32'h22);
    rd(8'h0C, 32'h00);
    wb(1'b1, 8'h18, 8'hC0);
    rd(8'h18, 32'hC0);
    $display("overrun test done");
    chk(32'(woke), 32'h0);
    wb(1'b1, 8'h18, 8'hF0);
    wb(1'b1, 8'hA0, 8'h03);
    send(9'h1AB, 1'b1);
    chk(32'(woke), 32'h1);
    chk(32'(vvalid), 32'h1);
    chk(32'(vec), 32'h0004);
    rd(8'hA0, 32'h02);
    wb(1'b1, 8'hA0, 8'h00);
    chk(32'(vvalid), 32'h0);
    wb(1'b1, 8'h8C, 8'h00);
    chk(32'(irq), 32'h0);
    rd(8'h0C, 32'h20);
    rd(8'h1A, 32'hAB);
    $display("sleep test done");
    tally_and_finish();
  end
endmodule
